// ---- logic/csirq_regs.sv ----
// Operation
// - Flag-affecting instruction into status keeps its own zero, nibble and carry flags.
// - Watchdog-expiry and sleep bits ignore writes and reset to one.
// - In subtraction carry and nibble carry act as inverted borrows.
// - Edge select bit picks rising or falling external pin edge.
// - Timer0 source bit picks external pin or instruction clock.
// - Timer0 edge bit picks falling or rising external clock edge.
// - Prescale n divides timer0 by 2^(n+1) or watchdog by 2^n.
// - Prescaler on watchdog leaves timer0 undivided, and vice versa.
// - Flags set on their condition regardless of any enable.
// - Global enable allows unmasked interrupts, clear blocks every interrupt.
// - Peripheral enable must be set with an individual peripheral enable.
// - Timer0, external pin and port change interrupts have own enables.
// - External pin flag set on chosen edge, held until software clears.
// - Timer2 match flag set on match, held until software clears.
// - Timer1 overflow flag set on overflow, held until software clears.
// - Second enable and flag words: bits 7-1 read zero, bit 0 second capture.
// - Brownout flag set by software; hardware clears it on brownout reset.
//
// Purpose: Status, option and interrupt register bank of a small 8-bit core.
// Assumes: Avalon-MM slave, one wait state on every access; events are one-cycle pulses.
// Notes:   Hardware set wins over a software clear in the same cycle.
`timescale 1ns/1ns
module csirq_regs #(
  parameter int PRE_W = 8
) (
  // Clock and reset.
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  // Avalon-MM slave.
  input  wire logic [10:0]          avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic      [31:0]          avs_readdata_out,
  output logic                      avs_waitrequest_out,
  // Core side.
  input  wire csirq_pkg::csirq_alu_type alu_in,
  input  wire logic                 clear_wdog_in,
  input  wire logic                 wdog_expire_in,
  input  wire logic                 sleep_enter_in,
  input  wire logic [6:0]           direct_addr_in,
  input  wire logic [7:0]           indirect_ptr_in,
  output logic      [8:0]           direct_addr_out,
  output logic      [8:0]           indirect_addr_out,
  output logic      [7:0]           alu_result_out,
  output logic                      port_pullup_disable_out,
  // Pins, asynchronous.
  input  wire logic                 ext_irq_pin_in,
  input  wire logic                 timer0_ext_clock_pin_in,
  // Event sources.
  input  wire logic                 wdog_osc_tick_in,
  input  wire logic                 port_change_in,
  input  wire logic [7:0]           periph_evt_a_in,
  input  wire logic                 serial_rx_flag_in,
  input  wire logic                 serial_tx_flag_in,
  input  wire logic                 capcmp_b_evt_in,
  input  wire logic                 por_evt_in,
  input  wire logic                 brownout_reset_in,
  // Timer and interrupt outputs.
  output logic      [7:0]           timer0_count_out,
  output logic                      wdog_tick_out,
  output logic                      irq_req_out
);
  import csirq_pkg::*;

  // Register state.
  logic [7:0] status_ff, option_ff, irqctl_ff;
  logic [7:0] pflag_a_ff, pen_a_ff, pwr_ff;
  logic       pflag_b_ff, pen_b_ff;
  logic [7:0] nxt_status, nxt_irqctl, nxt_pflag_a, nxt_pwr;
  logic       nxt_pflag_b;
  logic [7:0] t0_cnt_ff;
  logic [PRE_W-1:0] pre_cnt_ff;
  logic       ack_ff, wdog_tick_ff;
  logic [31:0] rdata_ff;
  logic [7:0] res_ff;
  logic       int_s1_ff, int_s2_ff, int_prev_ff;
  logic       t0p_s1_ff, t0p_s2_ff, t0p_prev_ff;

  // Bus decode; the index is the byte address over four.
  wire [8:0] idx     = avs_address_in[10:2];
  wire       req     = avs_read_in | avs_write_in;
  wire       wr_take = avs_write_in & ack_ff;
  wire       wr_st   = wr_take & (idx == IDX_STATUS);
  wire       wr_op   = wr_take & (idx == IDX_OPTION);
  wire       wr_ic   = wr_take & (idx == IDX_IRQCTL);
  wire       wr_fa   = wr_take & (idx == IDX_PFLAG_A);
  wire       wr_fb   = wr_take & (idx == IDX_PFLAG_B);
  wire       wr_ea   = wr_take & (idx == IDX_PEN_A);
  wire       wr_eb   = wr_take & (idx == IDX_PEN_B);
  wire       wr_pw   = wr_take & (idx == IDX_PWR);
  wire [7:0] wd      = avs_writedata_in[7:0];

  // Requests wait exactly one cycle so read data can come from a flop.
  assign avs_waitrequest_out = req & ~ack_ff;
  assign avs_readdata_out    = rdata_ff;

  // Read multiplexer; unmapped indices read as zero.
  wire [7:0] rd_sel =
    (idx == IDX_STATUS)  ? status_ff :
    (idx == IDX_OPTION)  ? option_ff :
    (idx == IDX_IRQCTL)  ? irqctl_ff :
    (idx == IDX_PFLAG_A) ? pflag_a_ff :
    (idx == IDX_PFLAG_B) ? {7'h00, pflag_b_ff} :
    (idx == IDX_PEN_A)   ? pen_a_ff :
    (idx == IDX_PEN_B)   ? {7'h00, pen_b_ff} :
    (idx == IDX_PWR)     ? pwr_ff : 8'h00;

  // Bus handshake and read capture.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= req & ~ack_ff;
      if (avs_read_in & ~ack_ff) begin
        rdata_ff <= {24'h00_0000, rd_sel};
      end
    end
  end

  // subtract as add of complement
  // A subtract adds the complement plus one, so carry-out means no borrow.
  wire [7:0] opb   = alu_in.sub ? ~alu_in.b : alu_in.b;
  wire       cin   = alu_in.sub;
  wire [4:0] nib   = {1'b0, alu_in.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  wire [8:0] sum   = {1'b0, alu_in.a} + {1'b0, opb} + {8'h00, cin};
  wire       f_z   = (sum[7:0] == 8'h00);

  // Status next value.
  always_comb begin
    nxt_status = status_ff;
    if (wr_st) begin
      nxt_status[ST_IRP] = wd[ST_IRP];
      nxt_status[ST_RP1] = wd[ST_RP1];
      nxt_status[ST_RP0] = wd[ST_RP0];
      nxt_status[ST_Z]   = wd[ST_Z];
      nxt_status[ST_DC]  = wd[ST_DC];
      nxt_status[ST_C]   = wd[ST_C];
    end
    if (alu_in.upd) begin
      nxt_status[ST_Z]  = f_z;
      nxt_status[ST_DC] = nib[4];
      nxt_status[ST_C]  = sum[8];
    end
    if (clear_wdog_in) begin
      nxt_status[ST_WDX] = 1'b1;
      nxt_status[ST_SLP] = 1'b1;
    end
    if (wdog_expire_in) begin
      nxt_status[ST_WDX] = 1'b0;
    end
    if (sleep_enter_in) begin
      nxt_status[ST_SLP] = 1'b0;
    end
  end

  // Status, option and result registers.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      status_ff <= RST_STATUS;
      option_ff <= RST_OPTION;
      res_ff    <= RST_ZERO;
    end else begin
      status_ff <= nxt_status;
      if (wr_op) begin
        option_ff <= wd;
      end
      if (alu_in.upd) begin
        res_ff <= sum[7:0];
      end
    end
  end
  assign alu_result_out          = res_ff;
  assign port_pullup_disable_out = option_ff[OP_PUD];

  assign indirect_addr_out = {status_ff[ST_IRP], indirect_ptr_in};
  assign direct_addr_out = {status_ff[ST_RP1], status_ff[ST_RP0], direct_addr_in};

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      int_s1_ff   <= 1'b0;
      int_s2_ff   <= 1'b0;
      int_prev_ff <= 1'b0;
      t0p_s1_ff   <= 1'b0;
      t0p_s2_ff   <= 1'b0;
      t0p_prev_ff <= 1'b0;
    end else begin
      int_s1_ff   <= ext_irq_pin_in;
      int_s2_ff   <= int_s1_ff;
      int_prev_ff <= int_s2_ff;
      t0p_s1_ff   <= timer0_ext_clock_pin_in;
      t0p_s2_ff   <= t0p_s1_ff;
      t0p_prev_ff <= t0p_s2_ff;
    end
  end

  wire int_rise = int_s2_ff & ~int_prev_ff;
  wire int_fall = ~int_s2_ff & int_prev_ff;
  wire int_evt  = option_ff[OP_EDG] ? int_rise : int_fall;

  wire t0p_rise = t0p_s2_ff & ~t0p_prev_ff;
  wire t0p_fall = ~t0p_s2_ff & t0p_prev_ff;
  wire t0p_evt  = option_ff[OP_T0E] ? t0p_fall : t0p_rise;
  wire t0_src   = option_ff[OP_SRC] ? t0p_evt : 1'b1;

  // prescaler rate masks
  // The shared counter passes one tick per full rollover of the masked low bits.
  wire [2:0]       rate     = option_ff[2:0];
  wire             prescaler_assign      = option_ff[OP_PSA];
  wire [PRE_W-1:0] t0_mask  = PRE_W'((9'h002 << rate) - 9'h001);
  wire [PRE_W-1:0] wd_mask  = PRE_W'((9'h001 << rate) - 9'h001);
  wire [PRE_W-1:0] mask     = prescaler_assign ? wd_mask : t0_mask;
  wire             pre_src  = prescaler_assign ? wdog_osc_tick_in : t0_src;
  wire             pre_tick = pre_src & ((pre_cnt_ff & mask) == mask);
  wire             t0_inc   = prescaler_assign ? t0_src : pre_tick;
  wire             wd_inc   = prescaler_assign ? pre_tick : wdog_osc_tick_in;
  wire             t0_ovf   = t0_inc & (t0_cnt_ff == 8'hFF);

  // Prescaler and timer0 counter.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pre_cnt_ff   <= '0;
      t0_cnt_ff    <= 8'h00;
      wdog_tick_ff <= 1'b0;
    end else begin
      if (pre_src) begin
        pre_cnt_ff <= pre_cnt_ff + PRE_W'(1);
      end
      if (t0_inc) begin
        t0_cnt_ff <= t0_cnt_ff + 8'h01;
      end
      wdog_tick_ff <= wd_inc;
    end
  end
  assign timer0_count_out = t0_cnt_ff;
  assign wdog_tick_out    = wdog_tick_ff;

  // Interrupt control word; events override a same-cycle clear.
  always_comb begin
    nxt_irqctl = wr_ic ? wd : irqctl_ff;
    if (t0_ovf) begin
      nxt_irqctl[IC_T0IF] = 1'b1;
    end
    if (int_evt) begin
      nxt_irqctl[IC_EXT_PIN_IRQ_FLAG] = 1'b1;
    end
    if (port_change_in) begin
      nxt_irqctl[IC_PORT_CHANGE_IRQ_FLAG] = 1'b1;
    end
  end

  // Peripheral flags; serial bits mirror their sources only.
  always_comb begin
    nxt_pflag_a = wr_fa ? wd : pflag_a_ff;
    nxt_pflag_a = nxt_pflag_a | periph_evt_a_in;
    nxt_pflag_a[PA_RX] = serial_rx_flag_in;
    nxt_pflag_a[PA_TX] = serial_tx_flag_in;
    nxt_pflag_b = (wr_fb ? wd[0] : pflag_b_ff) | capcmp_b_evt_in;
  end

  always_comb begin
    nxt_pwr = wr_pw ? (wd & 8'h03) : pwr_ff;
    if (por_evt_in) begin
      nxt_pwr[PW_POR] = 1'b0;
    end
    if (brownout_reset_in) begin
      nxt_pwr[PW_BOR] = 1'b0;
    end
  end

  // Interrupt and peripheral registers.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irqctl_ff  <= RST_ZERO;
      pflag_a_ff <= RST_ZERO;
      pflag_b_ff <= 1'b0;
      pen_a_ff   <= RST_ZERO;
      pen_b_ff   <= 1'b0;
      pwr_ff     <= RST_ZERO;
    end else begin
      irqctl_ff  <= nxt_irqctl;
      pflag_a_ff <= nxt_pflag_a;
      pflag_b_ff <= nxt_pflag_b;
      pwr_ff     <= nxt_pwr;
      if (wr_ea) begin
        pen_a_ff <= wd;
      end
      if (wr_eb) begin
        pen_b_ff <= wd[0];
      end
    end
  end

  wire core_hit = (irqctl_ff[IC_T0IE] & irqctl_ff[IC_T0IF])
                | (irqctl_ff[IC_INTE] & irqctl_ff[IC_EXT_PIN_IRQ_FLAG])
                | (irqctl_ff[IC_PORT_CHANGE_IRQ_ENABLE] & irqctl_ff[IC_PORT_CHANGE_IRQ_FLAG]);
  wire per_hit  = irqctl_ff[IC_PERIPH_IRQ_ENABLE]
                & ((|(pen_a_ff & pflag_a_ff)) | (pen_b_ff & pflag_b_ff));
  assign irq_req_out = irqctl_ff[IC_GIE] & (core_hit | per_hit);

  // Checks on the logic above.
  sequence s_req_wait;
    req & avs_waitrequest_out;
  endsequence
  sequence s_req_done;
    req & ~avs_waitrequest_out;
  endsequence

  a_bus_one_wait: assert property (@(posedge clock_in) disable iff (rst_in)
    s_req_wait ##1 req |-> s_req_done)
    else $error("Bus access did not finish after one wait.");

  a_flag_write_block: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_st & alu_in.upd |=> status_ff[ST_Z] == $past(f_z) && status_ff[ST_C] == $past(sum[8]))
    else $error("Status write overrode instruction flags.");

  a_ro_bits_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_st & ~clear_wdog_in & ~wdog_expire_in & ~sleep_enter_in
    |=> $stable(status_ff[ST_WDX:ST_SLP]))
    else $error("Read-only status bits changed on a write.");

  a_sub_borrow: assert property (@(posedge clock_in) disable iff (rst_in)
    alu_in.upd & alu_in.sub |=> status_ff[ST_C] == ($past(alu_in.a) >= $past(alu_in.b)))
    else $error("Borrow flag sense wrong in subtract.");

  a_add_carry: assert property (@(posedge clock_in) disable iff (rst_in)
    alu_in.upd & ~alu_in.sub
    |=> status_ff[ST_C] == ((9'($past(alu_in.a)) + 9'($past(alu_in.b))) > 9'h0FF))
    else $error("Add carry flag wrong.");

  a_add_nibble: assert property (@(posedge clock_in) disable iff (rst_in)
    alu_in.upd & ~alu_in.sub
    |=> status_ff[ST_DC] == ((5'($past(alu_in.a[3:0])) + 5'($past(alu_in.b[3:0]))) > 5'h0F))
    else $error("Nibble carry flag wrong.");

  a_pin_edge_flag: assert property (@(posedge clock_in) disable iff (rst_in)
    int_rise & option_ff[OP_EDG]
    |=> irqctl_ff[IC_EXT_PIN_IRQ_FLAG] ##1 (irqctl_ff[IC_EXT_PIN_IRQ_FLAG] || $past(wr_ic)))
    else $error("Rising edge did not latch the pin flag.");

  a_set_wins: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_ic & ~wd[IC_T0IF] & t0_ovf |=> irqctl_ff[IC_T0IF])
    else $error("Timer0 overflow lost against a clear.");

  a_global_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    ~irqctl_ff[IC_GIE] |-> ~irq_req_out)
    else $error("Interrupt raised with global enable clear.");

  a_undiv_timer0: assert property (@(posedge clock_in) disable iff (rst_in)
    prescaler_assign & t0_src |=> t0_cnt_ff == $past(t0_cnt_ff) + 8'h01)
    else $error("Timer0 not undivided with prescaler on watchdog.");

  a_pen_b_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    avs_read_in & ~ack_ff & (idx == IDX_PEN_B || idx == IDX_PFLAG_B)
    |=> rdata_ff[7:1] == 7'h00)
    else $error("Unimplemented capture bits read non-zero.");

  a_serial_follow: assert property (@(posedge clock_in) disable iff (rst_in)
    1'b1 |=> pflag_a_ff[PA_RX] == $past(serial_rx_flag_in))
    else $error("Receive flag did not follow its source.");

endmodule // csirq_regs

// ---- logic/csirq_pkg.sv ----
// Purpose: Constants and carriers for the core status and interrupt register bank.
// Assumes: Registers sit at word index offsets; byte address is four times the index.
// Notes:   Reset values follow the power-on column; unknown bits reset to zero.
package csirq_pkg;
  // Register indices, one 32-bit word each on the bus.
  localparam logic [8:0] IDX_STATUS  = 9'h003;
  localparam logic [8:0] IDX_PFLAG_A = 9'h00C;
  localparam logic [8:0] IDX_PFLAG_B = 9'h00D;
  localparam logic [8:0] IDX_OPTION  = 9'h081;
  localparam logic [8:0] IDX_PEN_A   = 9'h08C;
  localparam logic [8:0] IDX_PEN_B   = 9'h08D;
  localparam logic [8:0] IDX_PWR     = 9'h08E;
  localparam logic [8:0] IDX_IRQCTL  = 9'h10B;
  // Status word fields.
  localparam int ST_IRP = 7;
  localparam int ST_RP1 = 6;
  localparam int ST_RP0 = 5;
  localparam int ST_WDX = 4;
  localparam int ST_SLP = 3;
  localparam int ST_Z   = 2;
  localparam int ST_DC  = 1;
  localparam int ST_C   = 0;
  // Option word fields.
  localparam int OP_PUD = 7;
  localparam int OP_EDG = 6;
  localparam int OP_SRC = 5;
  localparam int OP_T0E = 4;
  localparam int OP_PSA = 3;
  // Interrupt control word fields.
  localparam int IC_GIE  = 7;
  localparam int IC_PERIPH_IRQ_ENABLE = 6;
  localparam int IC_T0IE = 5;
  localparam int IC_INTE = 4;
  localparam int IC_PORT_CHANGE_IRQ_ENABLE = 3;
  localparam int IC_T0IF = 2;
  localparam int IC_EXT_PIN_IRQ_FLAG = 1;
  localparam int IC_PORT_CHANGE_IRQ_FLAG = 0;
  // Peripheral flag word A read-only serial bits.
  localparam int PA_RX = 5;
  localparam int PA_TX = 4;
  // Power word fields.
  localparam int PW_POR = 1;
  localparam int PW_BOR = 0;
  // Reset values.
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] PEN_B_MASK = 8'h01;
  // Operands and control of one flag-affecting instruction.
  typedef struct packed {
    logic       upd;
    logic       sub;
    logic [7:0] a;
    logic [7:0] b;
  } csirq_alu_type;
endpackage : csirq_pkg

// ---- tb/csirq_core_model.sv ----
// Purpose: Core and event-source model on the far side of the register bank.
// Assumes: Each task is entered just after a rising clock edge.
// Notes:   Events are one-cycle pulses; pins are held long enough to pass the synchroniser.
`timescale 1ns/1ns
module csirq_core_model (
  // Clock.
  input  wire logic                clock_in,
  // Core and event outputs.
  output csirq_pkg::csirq_alu_type alu_out,
  output logic [7:0]               evt_out,
  output logic [7:0]               evt_a_out,
  output logic                     osc_out,
  output logic                     ext_pin_out,
  output logic                     t0_pin_out,
  output logic                     rx_out,
  output logic                     tx_out
);
  import csirq_pkg::*;
  // Idle levels from time zero, so the bank never samples an unknown.
  initial begin
    alu_out = '0;
    {evt_out, evt_a_out, osc_out, ext_pin_out, t0_pin_out, rx_out, tx_out} = '0;
  end
  // One flag-affecting instruction per cycle while upd is held.
  task automatic alu_set(input logic upd, input logic sub, input logic [7:0] a,
                         input logic [7:0] b);
    @(posedge clock_in);
    alu_out <= {upd, sub, a, b};
  endtask
  // one-cycle conditions
  // The condition lasts one cycle, so only the flag can remember it.
  task automatic fire(input logic [15:0] m);
    @(posedge clock_in);
    {evt_a_out, evt_out} <= m;
    @(posedge clock_in);
    {evt_a_out, evt_out} <= 16'h0000;
  endtask
  // A pin level is held five cycles, longer than sync plus edge detect.
  task automatic pin(input logic sel_t0, input logic v);
    @(posedge clock_in);
    if (sel_t0) begin
      t0_pin_out <= v;
    end else begin
      ext_pin_out <= v;
    end
    repeat (5) @(posedge clock_in);
  endtask
  // Watchdog oscillator ticks on n consecutive cycles.
  task automatic osc_burst(input int n);
    @(posedge clock_in);
    osc_out <= 1'b1;
    repeat (n) @(posedge clock_in);
    osc_out <= 1'b0;
  endtask
  // Serial receive and transmit status levels.
  task automatic serial(input logic rx, input logic tx);
    @(posedge clock_in);
    rx_out <= rx;
    tx_out <= tx;
  endtask
endmodule // csirq_core_model

// ---- tb/test_csirq_regs.sv ----
// Purpose: Self-checking bench for the status, option and interrupt register bank.
// Assumes: Requests rise after a rising edge and end at the edge that sees waitrequest low.
// Notes:   Reading at the falling edge sees settled values and never races the clock edge.
`timescale 1ns/1ns
module test_csirq_regs;
  import csirq_pkg::*;
  // Bench signals.
  logic          clock_in;
  logic          rst_in;
  logic [10:0]   avs_address_in;
  logic          avs_read_in;
  logic          avs_write_in;
  logic [31:0]   avs_writedata_in;
  logic [31:0]   avs_readdata_out;
  logic          avs_waitrequest_out;
  csirq_alu_type alu;
  logic [7:0]    evt;
  logic [7:0]    evt_a;
  logic          osc, ext_pin, t0_pin, rx, tx, pud, wd_tick, irq;
  logic [6:0]    dir_in;
  logic [7:0]    ind_in;
  logic [8:0]    dir_out, ind_out;
  logic [7:0]    alu_res, t0_cnt, c0, res, a, b;
  logic          s, z, dc, c;
  int            err_total = 0;
  int            num_checks = 0;
  int            wd_cnt = 0;
  int            w0;
  // Registers with their reset values, and operations as sub, a, b.
  logic [8:0]    regs [8] = '{IDX_STATUS, IDX_OPTION, IDX_IRQCTL, IDX_PFLAG_A, IDX_PFLAG_B,
                              IDX_PEN_A, IDX_PEN_B, IDX_PWR};
  logic [7:0]    rstv [8] = '{8'h18, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [16:0]   ops [6] = '{{1'b0, 8'h0F, 8'h01}, {1'b0, 8'hF0, 8'h10}, {1'b0, 8'h88, 8'h88},
                             {1'b1, 8'h05, 8'h06}, {1'b1, 8'h10, 8'h01}, {1'b1, 8'h33, 8'h33}};

  csirq_regs #(.PRE_W(8)) DUT (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .alu_in(alu), .clear_wdog_in(evt[0]),
    .wdog_expire_in(evt[1]), .sleep_enter_in(evt[2]), .direct_addr_in(dir_in),
    .indirect_ptr_in(ind_in), .direct_addr_out(dir_out), .indirect_addr_out(ind_out),
    .alu_result_out(alu_res), .port_pullup_disable_out(pud), .ext_irq_pin_in(ext_pin),
    .timer0_ext_clock_pin_in(t0_pin), .wdog_osc_tick_in(osc), .port_change_in(evt[3]),
    .periph_evt_a_in(evt_a), .serial_rx_flag_in(rx), .serial_tx_flag_in(tx),
    .capcmp_b_evt_in(evt[4]), .por_evt_in(evt[5]), .brownout_reset_in(evt[6]),
    .timer0_count_out(t0_cnt), .wdog_tick_out(wd_tick), .irq_req_out(irq));

  csirq_core_model u_core (
    .clock_in(clock_in), .alu_out(alu), .evt_out(evt), .evt_a_out(evt_a), .osc_out(osc),
    .ext_pin_out(ext_pin), .t0_pin_out(t0_pin), .rx_out(rx), .tx_out(tx));

  // Free-running 25 MHz clock.
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // Watchdog ticks are counted here, so a burst needs no cycle-exact sampling.
  always @(posedge clock_in) begin
    if (wd_tick === 1'b1) wd_cnt <= wd_cnt + 1;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One Avalon transfer; the request holds until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock_in);
    avs_address_in <= {idx, 2'b00};
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    avs_writedata_in <= {24'h000000, d};
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    // Read data is taken, and the write lands, at the edge that sees waitrequest low.
    q = avs_readdata_out[7:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 50) check("waitrequest", 16'h0001, 16'h0000);
  endtask
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdc(input string nm, input logic [8:0] idx, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    check(nm, {8'h00, x}, {8'h00, e});
  endtask
  task automatic irq_is(input logic e);
    @(negedge clock_in);
    check("irq_req", {15'h0000, irq}, {15'h0000, e});
  endtask
  task automatic t0_rate(input int n, input logic [7:0] e);
    @(negedge clock_in);
    c0 = t0_cnt;
    repeat (n) @(negedge clock_in);
    check("t0_count", {8'h00, t0_cnt - c0}, {8'h00, e});
  endtask

  // Main sequence.
  initial begin
    rst_in = 1'b1;
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, dir_in, ind_in} = '0;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    foreach (regs[i]) rdc("reset_value", regs[i], rstv[i]);
    wr(IDX_STATUS, 8'hE7);
    rdc("status_wr", IDX_STATUS, 8'hFF);
    wr(IDX_STATUS, 8'h00);
    rdc("status_wr", IDX_STATUS, 8'h18);
    u_core.fire(16'h0002);
    rdc("wdog_expiry", IDX_STATUS, 8'h08);
    u_core.fire(16'h0004);
    rdc("sleep_bit", IDX_STATUS, 8'h00);
    u_core.fire(16'h0001);
    rdc("wdog_clear", IDX_STATUS, 8'h18);
    for (int k = 0; k < 8; k++) begin
      wr(IDX_STATUS, {k[2:0], 5'h00});
      // Core addresses change with each bank, so the pass-through is really exercised.
      dir_in <= 7'(k * 7'h13 + 7'h05);
      ind_in <= 8'(8'hFF - k * 8'h25);
      @(negedge clock_in);
      check("direct_addr", {7'h00, dir_out}, {7'h00, k[1:0], dir_in});
      check("indirect_addr", {7'h00, ind_out}, {7'h00, k[2], ind_in});
    end
    for (int k = 0; k < 6; k++) begin
      {s, a, b} = ops[k];
      u_core.alu_set(1'b1, s, a, b);
      u_core.alu_set(1'b0, s, a, b);
      res = s ? a - b : a + b;
      c = s ? (a >= b) : ({1'b0, a} + {1'b0, b} > 9'h0FF);
      dc = s ? (a[3:0] >= b[3:0]) : ({1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0F);
      z = (res == 8'h00);
      @(negedge clock_in);
      check("alu_result", {8'h00, alu_res}, {8'h00, res});
      rdc("alu_flags", IDX_STATUS, {5'h1F, z, dc, c});
    end
    u_core.alu_set(1'b1, 1'b0, 8'h0F, 8'h01);
    wr(IDX_STATUS, 8'h05);
    u_core.alu_set(1'b0, 1'b0, 8'h0F, 8'h01);
    rdc("status_blocked", IDX_STATUS, 8'h1A);
    wr(IDX_OPTION, 8'h08);
    @(negedge clock_in);
    check("pullup_dis", {15'h0000, pud}, 16'h0000);
    t0_rate(32, 8'h20);
    for (int p = 0; p < 3; p++) begin
      wr(IDX_OPTION, {5'h00, p[2:0]});
      t0_rate(64, 8'(64 >> (p + 1)));
    end
    for (int e = 0; e < 2; e++) begin
      wr(IDX_OPTION, e ? 8'h38 : 8'h28);
      u_core.pin(1'b1, 1'b0);
      @(negedge clock_in);
      c0 = t0_cnt;
      for (int j = 0; j < 5; j++) u_core.pin(1'b1, ~j[0]);
      @(negedge clock_in);
      check("t0_ext", {8'h00, t0_cnt - c0}, e ? 16'h0002 : 16'h0003);
    end
    for (int k = 0; k < 2; k++) begin
      wr(IDX_OPTION, k ? 8'h22 : 8'h0A);
      @(negedge clock_in);
      w0 = wd_cnt;
      u_core.osc_burst(16);
      repeat (4) @(negedge clock_in);
      check("wdog_ticks", 16'(wd_cnt - w0), k ? 16'h0010 : 16'h0004);
    end
    wr(IDX_IRQCTL, 8'h00);
    u_core.fire(16'h0008);
    rdc("port_flag", IDX_IRQCTL, 8'h01);
    irq_is(1'b0);
    wr(IDX_IRQCTL, 8'h09);
    irq_is(1'b0);
    wr(IDX_IRQCTL, 8'h89);
    irq_is(1'b1);
    wr(IDX_IRQCTL, 8'h88);
    irq_is(1'b0);
    for (int e = 0; e < 2; e++) begin
      // Timer0 sits on its quiet pin here, so no overflow flag disturbs the reads.
      wr(IDX_OPTION, e ? 8'hE8 : 8'hA8);
      @(negedge clock_in);
      check("pullup_dis", {15'h0000, pud}, 16'h0001);
      u_core.pin(1'b0, ~e[0]);
      wr(IDX_IRQCTL, 8'h00);
      u_core.pin(1'b0, e[0]);
      rdc("ext_flag", IDX_IRQCTL, 8'h02);
      rdc("ext_flag_held", IDX_IRQCTL, 8'h02);
      wr(IDX_IRQCTL, 8'h00);
      u_core.pin(1'b0, ~e[0]);
      rdc("ext_other_edge", IDX_IRQCTL, 8'h00);
    end
    wr(IDX_PFLAG_A, 8'h00);
    wr(IDX_PEN_A, 8'h02);
    wr(IDX_IRQCTL, 8'h80);
    u_core.fire(16'h0200);
    rdc("tmr2_flag", IDX_PFLAG_A, 8'h02);
    irq_is(1'b0);
    wr(IDX_IRQCTL, 8'hC0);
    irq_is(1'b1);
    wr(IDX_IRQCTL, 8'h40);
    irq_is(1'b0);
    u_core.fire(16'h0100);
    repeat (10) @(posedge clock_in);
    rdc("tmr1_flag", IDX_PFLAG_A, 8'h03);
    u_core.serial(1'b1, 1'b0);
    wr(IDX_PFLAG_A, 8'h00);
    rdc("serial_flags", IDX_PFLAG_A, 8'h20);
    u_core.serial(1'b0, 1'b1);
    wr(IDX_PFLAG_A, 8'h20);
    rdc("serial_flags", IDX_PFLAG_A, 8'h10);
    wr(IDX_PEN_B, 8'hFF);
    rdc("enable_b", IDX_PEN_B, 8'h01);
    u_core.fire(16'h0010);
    rdc("flag_b", IDX_PFLAG_B, 8'h01);
    wr(IDX_PFLAG_B, 8'hFE);
    rdc("flag_b", IDX_PFLAG_B, 8'h00);
    wr(IDX_PWR, 8'hFF);
    rdc("power_set", IDX_PWR, 8'h03);
    u_core.fire(16'h0040);
    rdc("brownout", IDX_PWR, 8'h02);
    u_core.fire(16'h0020);
    rdc("power_on", IDX_PWR, 8'h00);
    wr(IDX_OPTION, 8'h08);
    wr(IDX_IRQCTL, 8'h20);
    repeat (260) @(posedge clock_in);
    rdc("t0_overflow", IDX_IRQCTL, 8'h24);
    irq_is(1'b0);
    wr(IDX_IRQCTL, 8'hA4);
    irq_is(1'b1);
    wr(9'h005, 8'hAA);
    rdc("unmapped", 9'h005, 8'h00);
    tally_and_finish();
  end
  // A hang is cut short well beyond the thousand or so cycles the tests need.
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule // test_csirq_regs
